// ---- verilog/kmp_host_port.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "kmp_regs.svh"
module kmp_host_port #(
    parameter int INHIBIT_CYC = `KMP_INHIBIT_CYC,
    parameter int TIMEOUT_CYC = `KMP_TIMEOUT_CYC,
    parameter bit TX_EN = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // link pins, index 0 primary, 1 secondary
    input wire logic [1:0] link_clk_in,
    output logic [1:0] link_clk_out,
    output logic [1:0] link_clk_oe,
    input wire logic [1:0] link_dat_in,
    output logic [1:0] link_dat_out,
    output logic [1:0] link_dat_oe,
    // command bytes toward the peripheral
    input wire logic [1:0] cmd_valid,
    input wire logic [1:0][7:0] cmd_data,
    output logic [1:0] cmd_ready,
    input wire logic [1:0] stream_req,
    // received bytes
    output logic [1:0] rx_valid,
    output logic [1:0][7:0] rx_data,
    output logic [1:0] rx_err,
    input wire logic [1:0] rx_ready,
    // status pulses
    output logic [1:0] frame_err,
    output logic [1:0] parity_err,
    output logic [1:0] overrun,
    output logic [1:0] ack_seen,
    output logic [1:0] tx_done,
    output logic [1:0] tx_nack
);
    localparam logic [15:0] INHIBIT_LAST = 16'(INHIBIT_CYC - 1);
    localparam logic [15:0] TIMEOUT_LAST = 16'(TIMEOUT_CYC - 1);

    kmp_pkg::kmp_top_s r;
    kmp_pkg::kmp_top_s n;
    logic [1:0] fall;
    logic [1:0] buf_ready;
    logic [1:0] tx_ok;

    // odd parity frame check
    function automatic logic frame_bad(input logic [10:0] f);
        frame_bad = f[`KMP_BIT_START] | ~f[`KMP_BIT_STOP] | ~(^f[`KMP_BIT_PARITY:1]);
    endfunction

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_port
            kmp_stream_if in_if ();
            kmp_stream_if out_if ();

            // falling edge of the synchronised link clock, not while we pull it low
            assign fall[g] = r.p[g].clk_prev & ~r.p[g].clk_s2 & ~r.p[g].clk_oe;
            assign tx_ok[g] = TX_EN && r.p[g].state == kmp_pkg::ST_IDLE
                && r.p[g].rx_cnt == 4'd0 && !fall[g];
            assign cmd_ready[g] = tx_ok[g] && !stream_req[g];

            // buffer in the received path
            assign in_if.valid = r.p[g].push;
            assign in_if.data = {r.p[g].push_err, r.p[g].push_data};
            assign buf_ready[g] = in_if.ready;
            assign overrun[g] = r.p[g].push & ~in_if.ready;
            assign rx_valid[g] = out_if.valid;
            assign rx_data[g] = out_if.data[7:0];
            assign rx_err[g] = out_if.data[8];
            assign out_if.ready = rx_ready[g];
            kmp_buf2 u_buf (
                .clk(clk),
                .rst_n(rst_n),
                .in_s(in_if.snk),
                .out_s(out_if.src)
            );

            // pin and pulse outputs
            assign link_clk_out[g] = 1'b0;
            assign link_dat_out[g] = 1'b0;
            assign link_clk_oe[g] = r.p[g].clk_oe;
            assign link_dat_oe[g] = r.p[g].dat_oe;
            assign frame_err[g] = r.p[g].frame_err;
            assign parity_err[g] = r.p[g].parity_err;
            assign ack_seen[g] = r.p[g].ack_seen;
            assign tx_done[g] = r.p[g].tx_done;
            assign tx_nack[g] = r.p[g].tx_nack;

            // checks
            sequence s_req_hold;
                r.p[g].state == kmp_pkg::ST_TX_REQ && r.p[g].clk_oe && !r.p[g].dat_oe;
            endsequence
            sequence s_handover;
                r.p[g].state == kmp_pkg::ST_TX_REQ ##1 r.p[g].state == kmp_pkg::ST_TX_BITS;
            endsequence

            property p_rx_fall;
                @(posedge clk) disable iff (!rst_n)
                ($changed(r.p[g].rx_cnt) && r.p[g].rx_cnt != 4'd0) |-> $past(fall[g]);
            endproperty
            a_rx_fall: assert property (p_rx_fall) else $error("bit taken off edge");

            property p_frame_check;
                @(posedge clk) disable iff (!rst_n)
                (fall[g] && r.p[g].state == kmp_pkg::ST_IDLE && r.p[g].rx_cnt == 4'd10)
                |=> r.p[g].push && r.p[g].rx_cnt == 4'd0
                && r.p[g].push_err == frame_bad(r.p[g].rx_sh);
            endproperty
            a_frame_check: assert property (p_frame_check) else $error("bad word check");

            property p_parity_flag;
                @(posedge clk) disable iff (!rst_n)
                (r.p[g].push && !(^r.p[g].rx_sh[9:1])) |-> r.p[g].parity_err && r.p[g].push_err;
            endproperty
            a_parity_flag: assert property (p_parity_flag) else $error("parity missed");

            property p_inhibit;
                @(posedge clk) disable iff (!rst_n)
                (TX_EN && r.p[g].state == kmp_pkg::ST_IDLE && r.p[g].rx_cnt == 4'd0
                && !fall[g] && !buf_ready[g]) |=> r.p[g].clk_oe;
            endproperty
            a_inhibit: assert property (p_inhibit) else $error("full but not inhibited");

            property p_no_drive;
                @(posedge clk) disable iff (!rst_n)
                !TX_EN |-> !r.p[g].clk_oe && !r.p[g].dat_oe;
            endproperty
            a_no_drive: assert property (p_no_drive) else $error("receive-only drove");

            property p_stream_cmd;
                @(posedge clk) disable iff (!rst_n)
                (tx_ok[g] && stream_req[g]) |=> r.p[g].state == kmp_pkg::ST_TX_REQ
                && r.p[g].tx_sh[7:0] == `KMP_CMD_SET_STREAM;
            endproperty
            a_stream_cmd: assert property (p_stream_cmd) else $error("stream cmd lost");

            property p_req_hold;
                @(posedge clk) disable iff (!rst_n)
                $rose(r.p[g].state == kmp_pkg::ST_TX_REQ) |-> s_req_hold [*8];
            endproperty
            a_req_hold: assert property (p_req_hold) else $error("request too short");

            property p_handover;
                @(posedge clk) disable iff (!rst_n)
                s_handover |-> r.p[g].dat_oe && !r.p[g].clk_oe && r.p[g].tx_cnt == 4'd0;
            endproperty
            a_handover: assert property (p_handover) else $error("no start bit");

            property p_tx_end;
                @(posedge clk) disable iff (!rst_n)
                (r.p[g].state == kmp_pkg::ST_TX_ACK && fall[g]) |=> r.p[g].tx_done
                && r.p[g].tx_nack == $past(r.p[g].dat_s2)
                && r.p[g].state == kmp_pkg::ST_IDLE;
            endproperty
            a_tx_end: assert property (p_tx_end) else $error("ack not sampled");

            property p_ack_fa;
                @(posedge clk) disable iff (!rst_n)
                (r.p[g].push && !r.p[g].push_err && r.p[g].push_data == `KMP_RSP_ACK)
                |-> r.p[g].ack_seen;
            endproperty
            a_ack_fa: assert property (p_ack_fa) else $error("answer not seen");
        end
    endgenerate

    // next state of both ports
    always_comb begin
        n = r;
        for (int i = 0; i < 2; i++) begin
            n.p[i].clk_s1 = link_clk_in[i];
            n.p[i].clk_s2 = r.p[i].clk_s1;
            n.p[i].clk_prev = r.p[i].clk_s2;
            n.p[i].dat_s1 = link_dat_in[i];
            n.p[i].dat_s2 = r.p[i].dat_s1;
            n.p[i].push = 1'b0;
            n.p[i].frame_err = 1'b0;
            n.p[i].parity_err = 1'b0;
            n.p[i].ack_seen = 1'b0;
            n.p[i].tx_done = 1'b0;
            n.p[i].tx_nack = 1'b0;
            if (r.p[i].timer != 16'hFFFF) begin
                n.p[i].timer = r.p[i].timer + 16'h0001;
            end
            case (r.p[i].state)
                kmp_pkg::ST_IDLE: begin
                    n.p[i].clk_oe = 1'b0;
                    n.p[i].dat_oe = 1'b0;
                    if (fall[i]) begin
                        n.p[i].rx_sh = {r.p[i].dat_s2, r.p[i].rx_sh[10:1]};
                        n.p[i].rx_cnt = r.p[i].rx_cnt + 4'd1;
                        n.p[i].timer = '0;
                        if (r.p[i].rx_cnt == 4'(`KMP_FRAME_BITS - 1)) begin
                            n.p[i].rx_cnt = 4'd0;
                            n.p[i].push = 1'b1;
                            n.p[i].push_data = n.p[i].rx_sh[8:1];
                            n.p[i].push_err = frame_bad(n.p[i].rx_sh);
                            n.p[i].frame_err = n.p[i].rx_sh[`KMP_BIT_START]
                                | ~n.p[i].rx_sh[`KMP_BIT_STOP];
                            n.p[i].parity_err = ~(^n.p[i].rx_sh[9:1]);
                            n.p[i].ack_seen = ~frame_bad(n.p[i].rx_sh)
                                && n.p[i].rx_sh[8:1] == `KMP_RSP_ACK;
                        end
                    end else if (r.p[i].rx_cnt != 4'd0 && r.p[i].timer == TIMEOUT_LAST) begin
                        n.p[i].rx_cnt = 4'd0;
                        n.p[i].frame_err = 1'b1;
                    end else if (tx_ok[i] && (stream_req[i] || cmd_valid[i])) begin
                        n.p[i].tx_sh[7:0] = stream_req[i] ? `KMP_CMD_SET_STREAM : cmd_data[i];
                        n.p[i].tx_sh[8] = ~(^n.p[i].tx_sh[7:0]);
                        n.p[i].tx_sh[9] = 1'b1;
                        n.p[i].state = kmp_pkg::ST_TX_REQ;
                        n.p[i].clk_oe = 1'b1;
                        n.p[i].timer = '0;
                    end
                    // hold clock low while buffer full
                    if (TX_EN && n.p[i].rx_cnt == 4'd0 && !buf_ready[i]) begin
                        n.p[i].clk_oe = 1'b1;
                    end
                end
                kmp_pkg::ST_TX_REQ: begin
                    // request to send, then start bit
                    if (r.p[i].timer == INHIBIT_LAST) begin
                        n.p[i].clk_oe = 1'b0;
                        n.p[i].dat_oe = 1'b1;
                        n.p[i].tx_cnt = 4'd0;
                        n.p[i].timer = '0;
                        n.p[i].state = kmp_pkg::ST_TX_BITS;
                    end
                end
                kmp_pkg::ST_TX_BITS, kmp_pkg::ST_TX_ACK: begin
                    if (fall[i]) begin
                        n.p[i].timer = '0;
                        if (r.p[i].state == kmp_pkg::ST_TX_BITS) begin
                            n.p[i].dat_oe = ~r.p[i].tx_sh[0];
                            n.p[i].tx_sh = {1'b1, r.p[i].tx_sh[9:1]};
                            n.p[i].tx_cnt = r.p[i].tx_cnt + 4'd1;
                            if (r.p[i].tx_cnt == 4'(`KMP_TX_BITS - 1)) begin
                                n.p[i].state = kmp_pkg::ST_TX_ACK;
                            end
                        end else begin
                            n.p[i].state = kmp_pkg::ST_IDLE;
                            n.p[i].tx_done = 1'b1;
                            n.p[i].tx_nack = r.p[i].dat_s2;
                        end
                    end else if (r.p[i].timer == TIMEOUT_LAST) begin
                        n.p[i].state = kmp_pkg::ST_IDLE;
                        n.p[i].dat_oe = 1'b0;
                        n.p[i].tx_done = 1'b1;
                        n.p[i].tx_nack = 1'b1;
                    end
                end
                default: begin
                    n.p[i].state = kmp_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // state register, synchronisers idle high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
            r.p[0].clk_s1 <= 1'b1;
            r.p[0].clk_s2 <= 1'b1;
            r.p[0].clk_prev <= 1'b1;
            r.p[0].dat_s1 <= 1'b1;
            r.p[0].dat_s2 <= 1'b1;
            r.p[1].clk_s1 <= 1'b1;
            r.p[1].clk_s2 <= 1'b1;
            r.p[1].clk_prev <= 1'b1;
            r.p[1].dat_s1 <= 1'b1;
            r.p[1].dat_s2 <= 1'b1;
        end else begin
            r <= n;
        end
    end
endmodule
`default_nettype wire

// ---- verilog/kmp_regs.svh ----
`ifndef KMP_REGS_SVH
`define KMP_REGS_SVH

// clock and timing
`define KMP_CLK_MHZ 125
`define KMP_INHIBIT_US 100
`define KMP_TIMEOUT_US 200
`define KMP_INHIBIT_CYC (`KMP_INHIBIT_US * `KMP_CLK_MHZ)
`define KMP_TIMEOUT_CYC (`KMP_TIMEOUT_US * `KMP_CLK_MHZ)
// frame layout
`define KMP_FRAME_BITS 11
`define KMP_TX_BITS 10
`define KMP_BIT_START 0
`define KMP_BIT_PARITY 9
`define KMP_BIT_STOP 10
// command and answer codes
`define KMP_CMD_SET_LAMPS 8'hED
`define KMP_CMD_ECHO 8'hEE
`define KMP_CMD_RATE 8'hF3
`define KMP_CMD_SET_STREAM 8'hEA
`define KMP_CMD_RESEND 8'hFE
`define KMP_CMD_RESET 8'hFF
`define KMP_RSP_ACK 8'hFA
`define KMP_CODE_KEY_UP 8'hF0
`define KMP_CODE_EXTENDED 8'hE0
// lamp byte bit positions
`define KMP_LAMP_SCROLL 0
`define KMP_LAMP_NUM 1
`define KMP_LAMP_CAPS 2
`endif

// ---- verilog/kmp_pkg.sv ----
package kmp_pkg;
    // port sequencer states
    typedef enum logic [1:0] {ST_IDLE, ST_TX_REQ, ST_TX_BITS, ST_TX_ACK} kmp_state_e;

    // state of one link port
    typedef struct packed {
        kmp_state_e state;
        logic clk_s1;
        logic clk_s2;
        logic clk_prev;
        logic dat_s1;
        logic dat_s2;
        logic [10:0] rx_sh;
        logic [3:0] rx_cnt;
        logic [9:0] tx_sh;
        logic [3:0] tx_cnt;
        logic [15:0] timer;
        logic clk_oe;
        logic dat_oe;
        logic push;
        logic [7:0] push_data;
        logic push_err;
        logic frame_err;
        logic parity_err;
        logic ack_seen;
        logic tx_done;
        logic tx_nack;
    } kmp_port_s;

    // whole top state, both ports
    typedef struct packed {
        kmp_port_s [1:0] p;
    } kmp_top_s;

    // two-entry buffer state
    typedef struct packed {
        logic [1:0] cnt;
        logic [8:0] e0;
        logic [8:0] e1;
    } kmp_buf_s;
endpackage

// ---- verilog/kmp_stream_if.sv ----
`timescale 1ns/10ps
`default_nettype none
// received word with error flag in bit 8
interface kmp_stream_if;
    logic valid;
    logic ready;
    logic [8:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ---- verilog/kmp_buf2.sv ----
`timescale 1ns/10ps
`default_nettype none
module kmp_buf2 (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // filling and draining sides
    kmp_stream_if.snk in_s,
    kmp_stream_if.src out_s
);
    kmp_pkg::kmp_buf_s r;
    kmp_pkg::kmp_buf_s n;
    logic push;
    logic pop;

    // handshakes from occupancy
    assign in_s.ready = (r.cnt != 2'd2);
    assign out_s.valid = (r.cnt != 2'd0);
    assign out_s.data = r.e0;
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready;

    // shift out at head, write at first free slot
    always_comb begin
        n = r;
        if (pop) begin
            n.e0 = r.e1;
        end
        if (push) begin
            if ((r.cnt - {1'b0, pop}) == 2'd0) begin
                n.e0 = in_s.data;
            end else begin
                n.e1 = in_s.data;
            end
        end
        n.cnt = r.cnt + {1'b0, push} - {1'b0, pop};
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // a full buffer refuses and keeps its count
    property p_buf_full_hold;
        @(posedge clk) disable iff (!rst_n)
        (r.cnt == 2'd2 && !out_s.ready) |=> (r.cnt == 2'd2) && $stable(r.e0);
    endproperty
    a_buf_full_hold: assert property (p_buf_full_hold) else $error("buffer lost a word");
endmodule
`default_nettype wire

// ---- tb/kmp_periph_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// far-side keyboard or mouse on one open-drain pin pair
module kmp_periph_model (
    // wire levels
    input wire logic clk_line,
    input wire logic dat_line,
    // pull-down enables
    output logic clk_pd,
    output logic dat_pd
);
    logic busy, arg_next;
    logic [7:0] last_tx, prev_cmd;
    logic [2:0] lamps;
    logic [8:0] rx_q[$];
    // lines released at start
    initial begin
        clk_pd = 1'b0;
        dat_pd = 1'b0;
        busy = 1'b0;
        arg_next = 1'b0;
        last_tx = 8'h00;
        prev_cmd = 8'h00;
        lamps = 3'h0;
    end
    // one word toward the host, lines released after
    task automatic send_word(input logic [7:0] b, input logic bad_par, input logic bad_stop);
        logic [10:0] w;
        int n;
        // start only after an idle stretch
        n = 0;
        while (n < 40) begin
            #10;
            n = (clk_line && dat_line && !busy) ? n + 1 : 0;
        end
        busy = 1'b1;
        // start, data lsb first, odd parity, stop
        w = {~bad_stop, ~^b ^ bad_par, b, 1'b0};
        // eleven clock pulses at bench link rate
        for (int i = 0; i < 11; i++) begin
            dat_pd = ~w[i];
            #30 clk_pd = 1'b1;
            #62.5 clk_pd = 1'b0;
            #32.5;
        end
        dat_pd = 1'b0;
        last_tx = b;
        busy = 1'b0;
    endtask
    // host request: clock pulled low, released with data low
    always begin
        logic [9:0] bits;
        logic [7:0] rep;
        // clock may already be low when the request starts, so key on its release
        @(posedge clk_line);
        #1;
        if (!busy) begin
            if (dat_line === 1'b0) begin
                busy = 1'b1;
                for (int k = 0; k < 11; k++) begin
                    #40 dat_pd = (k == 10);
                    clk_pd = 1'b1;
                    #62.5 clk_pd = 1'b0;
                    if (k < 10) bits[k] = dat_line;
                    #22.5;
                end
                dat_pd = 1'b0;
                rx_q.push_back({~(^bits[8:0]) | ~bits[9], bits[7:0]});
                rep = 8'hFA;
                // byte after lamp command sets lamps
                if (arg_next && prev_cmd == 8'hED) lamps = bits[2:0];
                if (!arg_next && bits[7:0] == 8'hEE) rep = 8'hEE;
                if (!arg_next && bits[7:0] == 8'hFE) rep = last_tx;
                if (!arg_next && bits[7:0] == 8'hFF) lamps = 3'h0;
                // lamp and rate commands take one byte more
                arg_next = !arg_next && (bits[7:0] == 8'hED || bits[7:0] == 8'hF3);
                prev_cmd = bits[7:0];
                busy = 1'b0;
                send_word(rep, 1'b0, 1'b0);
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/tb_kmp_host_port.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_kmp_host_port;
    logic clk, rst_n, rnd_ready;
    logic [1:0] cmd_valid, cmd_ready, stream_req, rx_valid, rx_err, rx_ready;
    logic [1:0][7:0] cmd_data, rx_data;
    logic [1:0] frame_err, parity_err, overrun, ack_seen, tx_done, tx_nack;
    logic [1:0] clk_oe, dat_oe, m_clk_pd, m_dat_pd, clk_line, dat_line;
    logic [1:0] clk_o, dat_o, ro_oe_c, ro_oe_d, ro_valid;
    int ro_drive = 0;
    int ro_words = 0;
    int err_total = 0;
    int compares = 0;
    int cnt[6][2] = '{default: 0};
    logic [8:0] exp_q[2][$];
    logic [7:0] cmds[8] = '{8'hED, 8'h05, 8'hF3, 8'h2A, 8'hEA, 8'hEE, 8'hFE, 8'hFF};
    logic [7:0] reps[8] = '{8'hFA, 8'hFA, 8'hFA, 8'hFA, 8'hFA, 8'hEE, 8'hEE, 8'hFA};
    logic [7:0] seq[9];
    logic [7:0] b, c;

    // open-drain lines with pull-ups
    assign clk_line = ~(clk_oe | m_clk_pd);
    assign dat_line = ~(dat_oe | m_dat_pd);

    kmp_host_port #(.INHIBIT_CYC(20), .TIMEOUT_CYC(400)) u_dut (
        .clk(clk), .rst_n(rst_n), .link_clk_in(clk_line), .link_clk_out(clk_o),
        .link_clk_oe(clk_oe), .link_dat_in(dat_line), .link_dat_out(dat_o),
        .link_dat_oe(dat_oe), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
        .cmd_ready(cmd_ready), .stream_req(stream_req), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_err(rx_err), .rx_ready(rx_ready),
        .frame_err(frame_err), .parity_err(parity_err), .overrun(overrun),
        .ack_seen(ack_seen), .tx_done(tx_done), .tx_nack(tx_nack));
    kmp_periph_model u_m0 (.clk_line(clk_line[0]), .dat_line(dat_line[0]),
        .clk_pd(m_clk_pd[0]), .dat_pd(m_dat_pd[0]));
    kmp_periph_model u_m1 (.clk_line(clk_line[1]), .dat_line(dat_line[1]),
        .clk_pd(m_clk_pd[1]), .dat_pd(m_dat_pd[1]));
    // receive-only listener on both pairs, asked to send all the time
    kmp_host_port #(.INHIBIT_CYC(20), .TIMEOUT_CYC(400), .TX_EN(1'b0)) u_ro (
        .clk(clk), .rst_n(rst_n), .link_clk_in(clk_line), .link_clk_out(),
        .link_clk_oe(ro_oe_c), .link_dat_in(dat_line), .link_dat_out(),
        .link_dat_oe(ro_oe_d), .cmd_valid(2'h3), .cmd_data(16'h0000),
        .cmd_ready(), .stream_req(2'h3), .rx_valid(ro_valid),
        .rx_data(), .rx_err(), .rx_ready(2'h3),
        .frame_err(), .parity_err(), .overrun(),
        .ack_seen(), .tx_done(), .tx_nack());

    // clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic final_report();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_n(input string what, input int exp, input int got);
        compares++;
        if (got != exp) begin
            err_total++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    // bounded wait until every expected word of a port was seen
    task automatic wait_q(input int p);
        int t;
        t = 0;
        while (exp_q[p].size() != 0 && t < 20000) begin
            @(posedge clk);
            t++;
        end
        if (t == 20000) begin
            err_total++;
            final_report();
        end
    endtask
    // one byte to the far side, held until the send starts
    task automatic host_cmd(input int p, input logic [7:0] v, input logic str);
        int t;
        t = 0;
        cmd_data[p] <= v;
        cmd_valid[p] <= !str;
        stream_req[p] <= str;
        while (clk_oe[p] !== 1'b1 && t < 2000) begin
            @(posedge clk);
            t++;
        end
        if (t == 2000) begin
            err_total++;
            final_report();
        end
        cmd_valid[p] <= 1'b0;
        stream_req[p] <= 1'b0;
    endtask
    // far side sends one word on port 1
    task automatic send1(input logic [7:0] v, input logic bp, input logic bs);
        exp_q[1].push_back({bp | bs, v});
        u_m1.send_word(v, bp, bs);
    endtask

    // score words and count status pulses
    always @(posedge clk) begin
        logic [5:0] ev;
        if (rst_n) begin
            ro_drive += int'((ro_oe_c | ro_oe_d) != 2'h0);
            ro_words += int'(ro_valid[1] === 1'b1);
            for (int i = 0; i < 2; i++) begin
                ev = {tx_nack[i], tx_done[i], ack_seen[i], overrun[i], parity_err[i],
                      frame_err[i]};
                for (int k = 0; k < 6; k++) cnt[k][i] += int'(ev[k] === 1'b1);
                if (rx_valid[i] === 1'b1 && rx_ready[i] === 1'b1)
                    chk("rx_word", exp_q[i].size() > 0 ? exp_q[i].pop_front() : 9'h1ff,
                        {rx_err[i], rx_data[i]});
            end
        end
    end
    // random stalls of the port 1 consumer
    always @(posedge clk) begin
        if (rnd_ready) rx_ready[1] <= ($urandom_range(3) != 0);
    end
    // watchdog
    initial begin
        #600000;
        err_total++;
        final_report();
    end

    initial begin
        rst_n = 1'b0;
        rnd_ready = 1'b0;
        cmd_valid = 2'h0;
        stream_req = 2'h0;
        cmd_data = 16'h0000;
        rx_ready = 2'h3;
        void'($urandom(32'h3cebc1fe));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // commands with replies on the primary pair
        for (int i = 0; i < 8; i++) begin
            exp_q[0].push_back({1'b0, reps[i]});
            host_cmd(0, cmds[i], cmds[i] == 8'hEA);
            wait_q(0);
            if (i == 1) chk("lamps", 9'h005, {6'h00, u_m0.lamps});
        end
        for (int i = 0; i < 8; i++) chk("host_tx", {1'b0, cmds[i]}, u_m0.rx_q[i]);
        chk_n("ack_seen", 6, cnt[3][0]);
        chk_n("tx_done", 8, cnt[4][0]);
        chk_n("tx_nack", 0, cnt[5][0]);
        // key traffic and a mouse report on the secondary pair, consumer stalling
        rnd_ready <= 1'b1;
        b = 8'($urandom_range(8'h7f, 8'h01));
        c = 8'($urandom_range(8'h7f, 8'h01));
        seq = '{b, b, 8'hF0, b, 8'hE0, c, 8'hE0, 8'hF0, c};
        for (int i = 0; i < 9; i++) send1(seq[i], 1'b0, 1'b0);
        // status: y_overflow_bit, x_overflow_bit, y_sign_bit, x_sign_bit, one, buttons
        send1({4'($urandom_range(15)), 1'b1, 3'($urandom_range(7))}, 1'b0, 1'b0);
        send1(8'($urandom), 1'b0, 1'b0);
        send1(8'($urandom), 1'b0, 1'b0);
        send1(8'h3C, 1'b1, 1'b0);
        send1(8'hC3, 1'b0, 1'b1);
        wait_q(1);
        chk_n("parity_err", 1, cnt[1][1]);
        chk_n("frame_err", 1, cnt[0][1]);
        chk_n("ro_words", 14, ro_words);
        // fill the primary buffer until the host inhibits the link
        rx_ready[0] <= 1'b0;
        for (int i = 0; i < 3; i++) exp_q[0].push_back({1'b0, 8'(8'h40 + i)});
        fork
            begin
                u_m0.send_word(8'h40, 1'b0, 1'b0);
                u_m0.send_word(8'h41, 1'b0, 1'b0);
                u_m0.send_word(8'h42, 1'b0, 1'b0);
            end
        join_none
        repeat (2000) @(posedge clk);
        chk("inhibit", 9'h001, {8'h00, clk_oe[0]});
        chk("held_word", 9'h041, {1'b0, u_m0.last_tx});
        rx_ready[0] <= 1'b1;
        wait_q(0);
        chk_n("overrun", 0, cnt[2][0]);
        chk_n("ro_drive", 0, ro_drive);
        chk("pin_low", 9'h000, {5'h00, clk_o, dat_o});
        final_report();
    end
endmodule
`default_nettype wire
